// ### bench/cfps_asserts.sv
// port assertions for the sequencer
`timescale 1ns/100ps
`default_nettype none
module cfps_asserts (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic en_i,
  input wire logic [3:0] phase_o,
  input wire logic [12:0] pc_o,
  input wire logic [12:0] pmem_addr_o,
  input wire logic [7:0] dmem_addr_o,
  input wire logic dmem_rd_o,
  input wire logic dmem_wr_o,
  input wire logic dmem_sfr_o,
  input wire logic irq_ack_o,
  input wire logic instr_valid_o,
  input wire logic [4:0] pc_high_latch_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  a_phase_onehot: assert property ($onehot(phase_o))
    else $error("phase not one-hot");
  a_phase_rotate: assert property (en_i |=> phase_o ==
    {$past(phase_o[2:0]), $past(phase_o[3])}) else $error("phase order");
  a_pc_step: assert property (en_i && phase_o == 4'h1 |=>
    pc_o == $past(pc_o) + 13'h1 && pmem_addr_o == $past(pc_o))
    else $error("pc step");
  a_read_slot: assert property (dmem_rd_o |-> phase_o == 4'h4)
    else $error("read slot");
  a_write_slot: assert property (dmem_wr_o |-> phase_o == 4'h1)
    else $error("write slot");
  a_alias_addr: assert property (dmem_rd_o || dmem_wr_o |->
    dmem_addr_o[7:4] != 4'hF) else $error("alias missed");
  a_sfr_flag: assert property (dmem_wr_o |->
    dmem_sfr_o == (dmem_addr_o[6:5] == 2'h0)) else $error("sfr flag");
  a_pc_reset: assert property ($rose(rst_n_i) |->
    pc_o == 13'h0 && phase_o == 4'h1) else $error("reset state");
  a_irq_vector: assert property (irq_ack_o |-> pc_o == 13'h4 &&
    $stable(pc_high_latch_o)) else $error("vector");
  c_irq: cover property (irq_ack_o);
  c_sfr_write: cover property (dmem_wr_o && dmem_sfr_o);
  c_bubble: cover property (!instr_valid_o && phase_o == 4'h2);
endmodule : cfps_asserts
bind cfps_sequencer cfps_asserts i_chk (.clk_i, .rst_n_i, .en_i, .phase_o,
  .pc_o, .pmem_addr_o, .dmem_addr_o, .dmem_rd_o, .dmem_wr_o, .dmem_sfr_o,
  .irq_ack_o, .instr_valid_o, .pc_high_latch_o);
`default_nettype wire

// ### bench/cfps_pmem_model.sv
// program memory model with asynchronous read
`timescale 1ns/100ps
`default_nettype none
module cfps_pmem_model
  import cfps_pkg::*;
(
  input wire logic [PC_W-1:0] addr_i,
  output logic [IW_W-1:0] data_o
);
  // the bench fills every word before reset is released
  logic [IW_W-1:0] mem [2**PC_W];
  assign data_o = mem[addr_i];
endmodule : cfps_pmem_model
`default_nettype wire

// ### bench/cfps_sequencer_tb.sv
// self-checking bench for the sequencer
`timescale 1ns/100ps
`default_nettype none
module cfps_sequencer_tb
  import cfps_pkg::*;
;
  logic clk_i = 0, rst_n_i = 0, en_i = 0, skip_i = 0, irq_i = 0, run = 0;
  logic [7:0] dest_data_i = 0, dmem_addr_o, dmem_wdata_o, ptr, d, low;
  logic [PC_W-1:0] pmem_addr_o, pc_o;
  logic [IW_W-1:0] pmem_data_i, instr_word_o;
  logic [4:0] latch;
  logic [3:0] phase_o, ph_p;
  logic dmem_rd_o, dmem_wr_o, dmem_sfr_o, irq_ack_o, instr_valid_o;
  logic bank, wr_p;
  logic [31:0] r = 32'h9491;
  logic [15:0] q_ex[$], q_wr[$];
  int failures = 0, n_tests = 0, cyc = 0, k = 0;
  // pc low byte write happens with the high latch loaded first
  localparam logic [13:0] P [9] = '{14'h00A1, 14'h0083, 14'h00FF, 14'h00A5,
    14'h0084, 14'h0080, 14'h008A, 14'h2123, 14'h0082};
  localparam logic [7:0] W [8] = '{8'h21, 8'h03, 8'h7F, 8'hA5, 8'h84,
    8'h30, 8'h8A, 8'h82};

  cfps_sequencer i_dut (.clk_i, .rst_n_i, .en_i, .pmem_addr_o, .pmem_data_i,
    .dest_data_i, .skip_i, .irq_i, .irq_ack_o, .dmem_addr_o, .dmem_rd_o,
    .dmem_wr_o, .dmem_wdata_o, .dmem_sfr_o, .instr_word_o, .instr_valid_o,
    .pc_o, .pc_low_byte_o(low), .pc_high_latch_o(latch),
    .bank_select_bit_o(bank), .indirect_pointer_reg_o(ptr), .phase_o);
  cfps_pmem_model i_pm (.addr_i(pmem_addr_o), .data_o(pmem_data_i));

  function automatic logic [31:0] nx(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : nx

  task cmp(input logic [15:0] g, input logic [15:0] e);
    n_tests++;
    if (g !== e) begin
      failures++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask : cmp

  task cmp_wr(input logic [15:0] g);
    cmp(g, q_wr.pop_front());
  endtask : cmp_wr

  task wrap_up;
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : wrap_up

  always #5 clk_i = ~clk_i;

  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 3000) begin
      failures++;
      wrap_up();
    end
  end

  // random stalls, result bytes, one skip and one interrupt
  always @(negedge clk_i) if (run) begin
    r = nx(r);
    d = r[15:8];
    en_i = r[0] | r[1];
    if (en_i && phase_o == 4'h8 && instr_valid_o &&
        instr_word_o[13:7] == 7'h01) begin
      case (instr_word_o[6:0])
        7'h03: d = 8'h20;
        7'h04: d = 8'h30;
        7'h0A: d = 8'h1F;
        7'h02: d = 8'h40;
        default: ;
      endcase
      q_wr.push_back({W[k], d});
      k++;
    end
    dest_data_i = d;
    skip_i = en_i && phase_o == 4'h8 && pmem_addr_o == 13'h1B01;
    // only a valid instruction may raise it, so the bubble after the
    // interrupt exit does not take the same interrupt again
    irq_i = !irq_ack_o && (irq_i || (en_i && phase_o == 4'h8 &&
      instr_valid_o && pmem_addr_o == 13'h1B03));
  end

  always @(negedge clk_i) begin
    if (dmem_wr_o && !wr_p) cmp_wr({dmem_addr_o, dmem_wdata_o});
    if (phase_o == 4'h2 && ph_p != 4'h2 && instr_valid_o && q_ex.size() > 0)
      cmp({3'h0, pmem_addr_o - 13'h1}, q_ex.pop_front());
    wr_p = dmem_wr_o;
    ph_p = phase_o;
  end

  initial begin
    for (int i = 0; i < 8192; i++) i_pm.mem[i] = OP_NOP;
    i_pm.mem[0] = 14'h2810;
    i_pm.mem[4] = OP_EXIT_FROM_INTERRUPT;
    for (int i = 0; i < 9; i++) i_pm.mem[16 + i] = P[i];
    i_pm.mem[13'h1923] = 14'h3455;
    i_pm.mem[13'h1F40] = 14'h2A00;
    for (int n = 0; n <= 16; n += 2) i_pm.mem[13'h1A00 + n] = 14'(14'h2202 + n);
    for (int n = 5; n <= 17; n += 2) i_pm.mem[13'h1A00 + n] = 14'(14'h3400 + n);
    i_pm.mem[13'h1A03] = 14'h2B00;
    i_pm.mem[13'h1A12] = OP_RETURN;
    q_ex = {16'h0};
    for (int i = 16; i < 24; i++) q_ex.push_back(16'(i));
    q_ex = {q_ex, 16'h1923, 16'h18, 16'h1F40};
    for (int n = 0; n <= 18; n += 2) q_ex.push_back(16'(16'h1A00 + n));
    for (int n = 17; n >= 3; n -= 2) q_ex.push_back(16'(16'h1A00 + n));
    q_ex = {q_ex, 16'h1B00, 16'h1B02, 16'h0004, 16'h1B03};
    repeat (10) @(posedge clk_i);
    @(negedge clk_i);
    cmp({3'h0, pc_o}, 16'h0);
    rst_n_i = 1;
    run = 1;
    while (q_ex.size() > 0) @(negedge clk_i);
    repeat (8) @(negedge clk_i);
    cmp({11'h0, latch}, 16'h1F);
    cmp({8'h0, ptr}, 16'h30);
    cmp({15'h0, bank}, 16'h1);
    cmp(16'(q_wr.size()), 16'h0);
    $display("trace test done");
    run = 0;
    rst_n_i = 0;
    #1;
    cmp({3'h0, pc_o}, 16'h0);
    cmp({12'h0, phase_o}, 16'h1);
    $display("reset test done");
    wrap_up();
  end
endmodule : cfps_sequencer_tb
`default_nettype wire

// ### core/cfps_phase_gen.sv
// divide-by-four phase sequencer
`timescale 1ns/100ps
`default_nettype none
module cfps_phase_gen
  import cfps_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic en_i,
  output cfps_phase_e phase_o
);
  typedef struct packed {
    cfps_phase_e ph;
  } cfps_ph_s;

  cfps_ph_s s_q;
  cfps_ph_s s_d;

  always_comb begin
    s_d = s_q;
    case (s_q.ph)
      PH_ONE: s_d.ph = PH_TWO;
      PH_TWO: s_d.ph = PH_THREE;
      PH_THREE: s_d.ph = PH_FOUR;
      PH_FOUR: s_d.ph = PH_ONE;
      default: s_d.ph = PH_ONE;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_q <= '{ph: PH_ONE};
    end else if (en_i) begin
      s_q <= s_d;
    end
  end

  assign phase_o = s_q.ph;
endmodule : cfps_phase_gen
`default_nettype wire

// ### core/cfps_pkg.sv
// constants and types for the fetch, pc and return stack sequencer
// Contract
// - four one-hot phases from the input clock
// - pc advances phase one, word captured phase four
// - fetch one cycle, execute next, overlapped
// - pc-changing instruction discards prefetch, two cycles
// - instruction latch loads phase one, executes after
// - operand read phase two, result write four
// - status bit five selects data bank
// - first 32 per bank special, 20h-7Fh ram
// - bank 1 F0h-FFh alias bank 0 70h-7Fh
// - registers reachable direct or through pointer
// - 13-bit pc, low byte writable, top latched
// - every reset clears the whole pc
// - low byte write loads top from latch
// - call and jump take latch bits four, three
// - eight-entry 13-bit stack, hidden pointer
// - push pc on call or interrupt vectoring
// - pop on return, literal return, interrupt return
// - push and pop leave high latch alone
// - circular stack, ninth push overwrites first
// - no overflow or underflow indication, silent wrap
package cfps_pkg;
  localparam int unsigned PC_W = 13;
  localparam int unsigned IW_W = 14;
  localparam int unsigned DEPTH = 8;
  localparam int unsigned SP_W = 3;
  localparam logic [PC_W-1:0] PC_RESET = 13'h0000;
  localparam logic [PC_W-1:0] IRQ_VECTOR = 13'h0004;
  localparam logic [PC_W-1:0] PC_ONE = 13'h0001;
  localparam logic [SP_W-1:0] SP_ONE = 3'h1;
  localparam int unsigned BANK_BIT = 5;
  localparam int unsigned LATCH_JUMP_LO = 3;
  localparam int unsigned TARGET_W = 11;
  localparam logic [6:0] SFR_LIMIT = 7'h20;
  localparam logic [6:0] ADDR_PCL = 7'h02;
  localparam logic [6:0] ADDR_STATUS = 7'h03;
  localparam logic [6:0] ADDR_POINTER = 7'h04;
  localparam logic [6:0] ADDR_LATCH = 7'h0A;
  localparam logic [6:0] ADDR_INDIRECT = 7'h00;
  localparam logic [3:0] ALIAS_TOP = 4'hF;
  localparam logic [IW_W-1:0] OP_RETURN = 14'h0008;
  localparam logic [IW_W-1:0] OP_EXIT_FROM_INTERRUPT = 14'h0009;
  localparam logic [IW_W-1:0] OP_NOP = 14'h0000;

  typedef enum logic [3:0] {
    PH_ONE = 4'h1,
    PH_TWO = 4'h2,
    PH_THREE = 4'h4,
    PH_FOUR = 4'h8
  } cfps_phase_e;
endpackage : cfps_pkg

// ### core/cfps_sequencer.sv
// fetch/execute sequencer with pc, return stack and data addressing
`timescale 1ns/100ps
`default_nettype none
module cfps_sequencer
  import cfps_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic en_i,
  // program memory
  output logic [PC_W-1:0] pmem_addr_o,
  input wire logic [IW_W-1:0] pmem_data_i,
  // execute unit, same clock
  input wire logic [7:0] dest_data_i,
  input wire logic skip_i,
  input wire logic irq_i,
  output logic irq_ack_o,
  // data register file
  output logic [7:0] dmem_addr_o,
  output logic dmem_rd_o,
  output logic dmem_wr_o,
  output logic [7:0] dmem_wdata_o,
  output logic dmem_sfr_o,
  // visible state
  output logic [IW_W-1:0] instr_word_o,
  output logic instr_valid_o,
  output logic [PC_W-1:0] pc_o,
  output logic [7:0] pc_low_byte_o,
  output logic [4:0] pc_high_latch_o,
  output logic bank_select_bit_o,
  output logic [7:0] indirect_pointer_reg_o,
  output logic [3:0] phase_o
);
  typedef struct packed {
    logic [PC_W-1:0] pc;
    logic [PC_W-1:0] fetch_addr;
    logic [IW_W-1:0] prefetch;
    logic pre_valid;
    logic [IW_W-1:0] instruction_word_latch;
    logic ir_valid;
    logic [4:0] pc_high_latch;
    logic bank_select_bit;
    logic [7:0] indirect_pointer_reg;
    logic [SP_W-1:0] sp;
    logic [7:0] dmem_addr;
    logic dmem_rd;
    logic dmem_wr;
    logic [7:0] dmem_wdata;
    logic dmem_sfr;
    logic irq_ack;
  } cfps_top_s;

  cfps_top_s s_q;
  cfps_top_s s_d;
  cfps_phase_e phase;
  logic stk_we;
  logic [SP_W-1:0] stk_waddr;
  logic [PC_W-1:0] stk_wdata;
  logic [SP_W-1:0] stk_raddr;
  logic [PC_W-1:0] stk_rdata;

  // banked address of the file operand, pointer used for the indirect slot
  function automatic logic [7:0] map_addr(
    input logic [IW_W-1:0] iw,
    input logic bank,
    input logic [7:0] ptr
  );
    logic [7:0] a;
    if (iw[6:0] == ADDR_INDIRECT) begin
      a = ptr;
    end else begin
      a = {bank, iw[6:0]};
    end
    if (a[7:4] == ALIAS_TOP) begin
      a = {1'b0, a[6:0]};
    end
    return a;
  endfunction : map_addr

  // instruction names a file register it reads
  function automatic logic file_op(input logic [IW_W-1:0] iw);
    logic r;
    r = 1'b0;
    if (iw[13:12] == 2'b00 && iw[11:7] != 5'b00000) begin
      r = 1'b1;
    end
    if (iw[13:12] == 2'b01) begin
      r = 1'b1;
    end
    return r;
  endfunction : file_op

  // instruction writes its file register back
  function automatic logic file_wr(input logic [IW_W-1:0] iw);
    logic r;
    r = 1'b0;
    if (iw[13:12] == 2'b00 && iw[11:8] != 4'h0 && iw[7]) begin
      r = 1'b1;
    end
    if (iw[13:7] == 7'b0000001) begin
      r = 1'b1;
    end
    if (iw[13:11] == 3'b010) begin
      r = 1'b1;
    end
    return r;
  endfunction : file_wr

  cfps_phase_gen u_phase (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .en_i(en_i),
    .phase_o(phase)
  );

  cfps_stack_mem u_stack (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .en_i(en_i),
    .we_i(stk_we),
    .waddr_i(stk_waddr),
    .wdata_i(stk_wdata),
    .raddr_i(stk_raddr),
    .rdata_o(stk_rdata)
  );

  // top of stack is always being read, so it is ready by phase four
  assign stk_raddr = s_q.sp - SP_ONE;

  always_comb begin
    logic [IW_W-1:0] iw;
    logic is_call;
    logic is_goto;
    logic is_ret;
    logic xfer;
    logic [7:0] fa;
    iw = s_q.instruction_word_latch;
    is_call = 1'b0;
    is_goto = 1'b0;
    is_ret = 1'b0;
    xfer = 1'b0;
    fa = map_addr(iw, s_q.bank_select_bit, s_q.indirect_pointer_reg);
    s_d = s_q;
    s_d.dmem_rd = 1'b0;
    s_d.dmem_wr = 1'b0;
    s_d.irq_ack = 1'b0;
    stk_we = 1'b0;
    stk_waddr = s_q.sp;
    stk_wdata = s_q.fetch_addr;
    if (s_q.ir_valid) begin
      is_call = (iw[13:11] == 3'b100);
      is_goto = (iw[13:11] == 3'b101);
      is_ret = (iw == OP_RETURN) || (iw == OP_EXIT_FROM_INTERRUPT) ||
               (iw[13:10] == 4'b1101);
    end
    case (phase)
      PH_ONE: begin
        s_d.instruction_word_latch = s_q.prefetch;
        s_d.ir_valid = s_q.pre_valid;
        s_d.fetch_addr = s_q.pc;
        s_d.pc = s_q.pc + PC_ONE;
      end
      PH_TWO: begin
        if (s_q.ir_valid && file_op(iw)) begin
          s_d.dmem_rd = 1'b1;
          s_d.dmem_addr = fa;
          s_d.dmem_sfr = (fa[6:0] < SFR_LIMIT);
        end
      end
      PH_THREE: begin
        s_d.dmem_sfr = s_q.dmem_sfr;
      end
      PH_FOUR: begin
        s_d.prefetch = pmem_data_i;
        s_d.pre_valid = 1'b1;
        if (is_call || is_goto) begin
          s_d.pc = {s_q.pc_high_latch[4:LATCH_JUMP_LO],
                    iw[TARGET_W-1:0]};
          xfer = 1'b1;
        end
        if (is_call) begin
          stk_we = 1'b1;
          s_d.sp = s_q.sp + SP_ONE;
        end
        if (is_ret) begin
          s_d.pc = stk_rdata;
          s_d.sp = s_q.sp - SP_ONE;
          xfer = 1'b1;
        end
        if (s_q.ir_valid && file_wr(iw)) begin
          s_d.dmem_wr = 1'b1;
          s_d.dmem_addr = fa;
          s_d.dmem_wdata = dest_data_i;
          s_d.dmem_sfr = (fa[6:0] < SFR_LIMIT);
          case (fa[6:0])
            ADDR_PCL: begin
              s_d.pc = {s_q.pc_high_latch, dest_data_i};
              xfer = 1'b1;
            end
            ADDR_LATCH: begin
              s_d.pc_high_latch = dest_data_i[4:0];
            end
            ADDR_STATUS: begin
              s_d.bank_select_bit = dest_data_i[BANK_BIT];
            end
            ADDR_POINTER: begin
              s_d.indirect_pointer_reg = dest_data_i;
            end
            default: begin
              s_d.dmem_sfr = s_d.dmem_sfr;
            end
          endcase
        end
        if (irq_i && !xfer) begin
          stk_we = 1'b1;
          s_d.sp = s_q.sp + SP_ONE;
          s_d.pc = IRQ_VECTOR;
          s_d.irq_ack = 1'b1;
          xfer = 1'b1;
        end
        if (xfer || (s_q.ir_valid && skip_i)) begin
          s_d.pre_valid = 1'b0;
        end
      end
      default: begin
        s_d.dmem_sfr = s_q.dmem_sfr;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_q <= '0;
      s_q.prefetch <= OP_NOP;
      s_q.instruction_word_latch <= OP_NOP;
      s_q.pc <= PC_RESET;
      s_q.fetch_addr <= PC_RESET;
    end else if (en_i) begin
      s_q <= s_d;
    end
  end

  assign pmem_addr_o = s_q.fetch_addr;
  assign irq_ack_o = s_q.irq_ack;
  assign dmem_addr_o = s_q.dmem_addr;
  assign dmem_rd_o = s_q.dmem_rd;
  assign dmem_wr_o = s_q.dmem_wr;
  assign dmem_wdata_o = s_q.dmem_wdata;
  assign dmem_sfr_o = s_q.dmem_sfr;
  assign instr_word_o = s_q.instruction_word_latch;
  assign instr_valid_o = s_q.ir_valid;
  assign pc_o = s_q.pc;
  assign pc_low_byte_o = s_q.fetch_addr[7:0];
  assign pc_high_latch_o = s_q.pc_high_latch;
  assign bank_select_bit_o = s_q.bank_select_bit;
  assign indirect_pointer_reg_o = s_q.indirect_pointer_reg;
  assign phase_o = phase;
endmodule : cfps_sequencer
`default_nettype wire

// ### core/cfps_stack_mem.sv
// eight-word return stack storage with registered read data
`timescale 1ns/100ps
`default_nettype none
module cfps_stack_mem
  import cfps_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic en_i,
  input wire logic we_i,
  input wire logic [SP_W-1:0] waddr_i,
  input wire logic [PC_W-1:0] wdata_i,
  input wire logic [SP_W-1:0] raddr_i,
  output logic [PC_W-1:0] rdata_o
);
  typedef struct packed {
    logic [DEPTH-1:0][PC_W-1:0] mem;
    logic [PC_W-1:0] rd;
  } cfps_mem_s;

  cfps_mem_s s_q;
  cfps_mem_s s_d;

  always_comb begin
    s_d = s_q;
    s_d.rd = s_q.mem[raddr_i];
    if (we_i) begin
      s_d.mem[waddr_i] = wdata_i;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_q <= '0;
    end else if (en_i) begin
      s_q <= s_d;
    end
  end

  assign rdata_o = s_q.rd;
endmodule : cfps_stack_mem
`default_nettype wire
